// ===== bench/rtc_alarm_interrupt_tb_top.sv
`timescale 1ns/1ps
module rtc_alarm_interrupt_tb_top;
  localparam logic [7:0] SEC = rtcalm_pkg::ALARM_SECOND_MATCH_IDX;
  localparam logic [7:0] MIN = rtcalm_pkg::ALARM_MINUTE_MATCH_IDX;
  localparam logic [7:0] HOUR = rtcalm_pkg::ALARM_HOUR_MATCH_IDX;
  localparam logic [7:0] WD = rtcalm_pkg::ALARM_WEEKDAY_OR_DATE_MATCH_IDX;
  localparam logic [7:0] EXT = rtcalm_pkg::EXTENSION_CONFIG_IDX;
  localparam logic [7:0] FLG = rtcalm_pkg::EVENT_FLAGS_IDX;
  localparam logic [7:0] CTL = rtcalm_pkg::INTERRUPT_CONTROL_IDX;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hung, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic sec_tick, timer_tick, irq_n_o, irq_n_oe, timer_flag;
  logic [6:0] cal_sec, cal_min, cal_week;
  logic [5:0] cal_hour, cal_date;
  logic [7:0] v;
  logic [7:0] aidx [4] = '{SEC, MIN, HOUR, WD}; // Alarm registers
  int n_mismatch = 0;
  int n_compared = 0;
  wire irq_pin = irq_n_oe ? 1'b1 : irq_n_o; // Pull-up on open drain
  rtcalm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sec_tick(sec_tick), .timer_tick(timer_tick), .cal_sec(cal_sec),
    .cal_min(cal_min), .cal_hour(cal_hour), .cal_week(cal_week),
    .cal_date(cal_date), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe),
    .timer_flag(timer_flag));
  rtcalm_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hung(hung));
  // 250 MHz bus clock
  always #2 pclk = ~pclk;
  // Pin is low only with flag and enable both set
  function automatic logic pin_exp(logic f, logic en);
    return !(f && en);
  endfunction
  task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d);
    i_host.xfer(1'b1, {2'b00, i, 2'b00}, {24'h0, d}, r, e);
  endtask
  task automatic rd(logic [7:0] i, logic [7:0] x);
    i_host.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, r, e);
    chk("readback", {24'h0, x}, r);
  endtask
  // Alarm flag and interrupt pin checked together
  task automatic af(logic f, logic en);
    i_host.xfer(1'b0, {2'b00, FLG, 2'b00}, 32'h0, r, e);
    chk("alarm_flag", {31'h0, f}, {31'h0, r[rtcalm_pkg::ALARM_FLAG_BIT]});
    chk("irq_pin", {31'h0, pin_exp(f, en)}, {31'h0, irq_pin});
  endtask
  // New calendar value, then one second tick
  task automatic tick(logic [6:0] s, logic [6:0] w, logic [5:0] d);
    @(posedge pclk);
    cal_sec <= s;
    cal_week <= w;
    cal_date <= d;
    @(posedge pclk);
    sec_tick <= 1'b1;
    @(posedge pclk);
    sec_tick <= 1'b0;
    @(posedge pclk);
  endtask
  // Mode setup, a miss and then a hit
  task automatic wk(logic [7:0] x, logic [7:0] m, logic [6:0] w0,
    logic [6:0] w1, logic [5:0] d0, logic [5:0] d1);
    wr(EXT, x);
    wr(WD, m);
    tick(7'h00, w0, d0);
    af(1'b0, 1'b1);
    tick(7'h00, w1, d1);
    af(1'b1, 1'b1);
    wr(FLG, 8'h00);
  endtask
  task automatic tt(int k);
    repeat (k) begin
      @(posedge pclk);
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
    end
    @(posedge pclk);
  endtask
  task automatic end_of_test();
    if (hung) n_mismatch++;
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (50000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end
  // A bus wait that ran out ends the run at once
  always @(posedge hung) end_of_test();
  initial begin
    {pclk, presetn, sec_tick, timer_tick, cal_sec, cal_week} = '0;
    cal_date = 6'h01;
    cal_min = 7'h59;
    cal_hour = 6'h12;
    v = 8'($urandom(32'h7be1));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 8'h00);
    af(1'b0, 1'b0);
    foreach (aidx[i]) begin
      v = 8'($urandom);
      wr(aidx[i], v);
      rd(aidx[i], v);
    end
    i_host.xfer(1'b0, 12'h004, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    wr(CTL, 8'h00);
    wr(SEC, 8'h30);
    wr(MIN, 8'h80);
    wr(HOUR, 8'h80);
    wr(WD, 8'h80);
    wr(CTL, 8'h08);
    tick(7'h29, 7'h01, 6'h01);
    af(1'b0, 1'b1);
    tick(7'h30, 7'h01, 6'h01);
    af(1'b1, 1'b1);
    wr(FLG, 8'hff);
    af(1'b1, 1'b1);
    wr(CTL, 8'h00);
    af(1'b1, 1'b0);
    wr(CTL, 8'h08);
    af(1'b1, 1'b1);
    wr(FLG, 8'h00);
    af(1'b0, 1'b1);
    tick(7'h45, 7'h01, 6'h01);
    wr(SEC, 8'h45);
    tick(7'h45, 7'h01, 6'h01);
    af(1'b0, 1'b1);
    wr(CTL, 8'h09);
    tick(7'h30, 7'h01, 6'h01);
    tick(7'h45, 7'h01, 6'h01);
    af(1'b0, 1'b1);
    wr(CTL, 8'h08);
    wr(SEC, 8'h80);
    repeat (2) begin
      tick(7'h45, 7'h01, 6'h01);
      af(1'b1, 1'b1);
      wr(FLG, 8'h00);
    end
    wr(MIN, 8'h59);
    wk(8'h00, 8'h0a, 7'h01, 7'h08, 6'h01, 6'h01);
    wk(8'h00, 8'h0a, 7'h04, 7'h02, 6'h01, 6'h01);
    wk(8'h08, 8'h15, 7'h01, 7'h01, 6'h14, 6'h15);
    wr(rtcalm_pkg::WAKEUP_PRESET_IDX, 8'h03);
    wr(EXT, 8'h10);
    repeat (2) begin
      tt(2);
      chk("timer_flag", 32'h0, {31'h0, timer_flag});
      tt(1);
      chk("timer_flag", 32'h1, {31'h0, timer_flag});
      wr(FLG, 8'h00);
    end
    rd(rtcalm_pkg::WAKEUP_PRESET_IDX, 8'h03);
    rd(rtcalm_pkg::CALENDAR_NOW_IDX, 8'h03);
    end_of_test();
  end
endmodule

// ===== bench/rtcalm_host.sv
`timescale 1ns/1ps
// Host processor on the register bus, one transfer at a time
module rtcalm_host (
  input wire logic pclk, // Bus clock
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Byte address
  output logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  output logic hung // Slave never answered
);
  // Idle bus at time zero
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  end
  // Request held until pready is seen high, bounded wait
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung <= hung | (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== verilog/rtcalm_pkg.sv
package rtcalm_pkg;
  // Register indices; the APB byte address is four times the index
  localparam logic [7:0] ALARM_MINUTE_MATCH_IDX = 8'h17;
  localparam logic [7:0] ALARM_HOUR_MATCH_IDX = 8'h18;
  localparam logic [7:0] ALARM_WEEKDAY_OR_DATE_MATCH_IDX = 8'h19;
  localparam logic [7:0] EXTENSION_CONFIG_IDX = 8'h1d;
  localparam logic [7:0] EVENT_FLAGS_IDX = 8'h1e;
  localparam logic [7:0] INTERRUPT_CONTROL_IDX = 8'h1f;
  localparam logic [7:0] ALARM_SECOND_MATCH_IDX = 8'h2c;
  localparam logic [7:0] WAKEUP_PRESET_IDX = 8'h30;
  localparam logic [7:0] CALENDAR_NOW_IDX = 8'h31;
  // Field positions
  localparam int TERM_DISABLE_BIT = 7;
  localparam int WEEK_DAY_SELECT_BIT = 3;
  localparam int WAKEUP_TIMER_ENABLE_BIT = 4;
  localparam int ALARM_FLAG_BIT = 3;
  localparam int TIMER_FLAG_BIT = 4;
  localparam int ALARM_IRQ_ENABLE_BIT = 3;
  localparam int STOP_BIT = 0;
  // Reset values
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [23:0] PRESET_RESET = 24'h000000;
endpackage

// ===== verilog/rtcalm_top.sv
`timescale 1ns/1ps
// Operation
// - Reload preset and keep counting after expiry
// - Fresh countdown only on enable rising
// - Match sets alarm flag, pulls interrupt low
// - Interrupt stays low until host releases
// - Stop bit blocks alarm events
// - Alarm registers usable as plain storage
// - Register 19h read as week or date
// - Weekday bits independent, any selected matches
// - All terms disabled: event every second
// - Otherwise only a new match triggers event
// - Select 0 weekday, 1 day of month
// - Alarm flag sticky, cleared only by 0
// - Clearing flag releases interrupt output
// - Enable 1: event drives output low
// - Enable 0 blocks or releases output
// - Enable gates pin only, flag untouched
// - Interrupt is open-drain active low
module rtcalm_top (
  input wire logic pclk, // 250 MHz bus clock
  input wire logic presetn, // Async reset, active low
  // Register bus, slave side
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  // Calendar side, levels and one-cycle ticks
  input wire logic sec_tick, // One-cycle 1 Hz calendar tick
  input wire logic timer_tick, // One-cycle wake-up source tick
  input wire logic [6:0] cal_sec, // BCD seconds
  input wire logic [6:0] cal_min, // BCD minutes
  input wire logic [5:0] cal_hour, // BCD hours
  input wire logic [6:0] cal_week, // One-hot weekday
  input wire logic [5:0] cal_date, // BCD day of month
  // Interrupt pin and wake-up status
  output logic irq_n_o, // Interrupt drive value (always 0)
  output logic irq_n_oe, // Low while pin pulled low
  output logic timer_flag // Wake-up expiry flag
);
  typedef struct packed {
    // Alarm match registers, bit 7 disables the term
    logic [7:0] a_sec; // Second match
    logic [7:0] a_min; // Minute match
    logic [7:0] a_hour; // Hour match
    logic [7:0] a_wd; // Week or date match
    // Configuration bytes written by the host
    logic [7:0] ext; // Extension config
    logic [7:0] ctl; // Interrupt control
    // Sticky status and pin state
    logic af; // Alarm flag
    logic tf; // Timer flag
    logic irq_low; // Pin pulled low
    logic match_d; // Previous tick's match
    // Wake-up countdown
    logic [23:0] preset; // Wake-up preset
    logic [23:0] count; // Wake-up counter
    logic te_d; // Previous enable
    // Registered bus answer
    logic [31:0] rdata; // Read data
    logic rdy; // Ready
    logic err; // Error
  } rtcalm_s;
  // Current and next state
  rtcalm_s st;
  rtcalm_s next_st;
  // Decoded bus strobes and match terms
  logic wr; // Write strobe in setup
  logic rd; // Read strobe in setup
  logic [7:0] idx; // Word index
  logic match; // Combined alarm match
  logic hit_sec; // Second term hit
  logic hit_min; // Minute term hit
  logic hit_hour; // Hour term hit
  logic hit_wd; // Week or date term hit
  logic all_off; // All terms disabled
  logic te; // Wake-up enable bit
  logic mapped; // Address decodes
  // Bus answer in the cycle after setup: one wait-free access phase.
  // Writes land on the setup edge, so a read that follows at once
  // already sees the new value.
  // Byte address bits 9:2 carry the register index; the rest must be
  // zero or the transfer is refused.
  assign wr = psel && !penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign idx = paddr[9:2];
  assign te = st.ext[rtcalm_pkg::WAKEUP_TIMER_ENABLE_BIT];
  // Full alarm comparison against a chosen set of terms; used to
  // re-read the present time right after the host changes a term
  function automatic logic terms_hit(input logic [7:0] s,
    input logic [7:0] m, input logic [7:0] h, input logic [7:0] w,
    input logic sel);
    logic ws; // Week or date term
    ws = w[7] || (sel ? (w[5:0] == cal_date) : |(w[6:0] & cal_week));
    return (s[7] || (s[6:0] == cal_sec)) && (m[7] || (m[6:0] == cal_min))
      && (h[7] || (h[5:0] == cal_hour)) && ws;
  endfunction
  // Term comparisons; a disabled term counts as a hit so that the
  // remaining terms alone decide the match.
  // Hours and dates use six bits, seconds and minutes seven.
  // Week mode ANDs the one-hot weekday with the mask, so several
  // days may be armed together.
  always_comb begin
    hit_sec = st.a_sec[rtcalm_pkg::TERM_DISABLE_BIT] ||
      (st.a_sec[6:0] == cal_sec);
    hit_min = st.a_min[rtcalm_pkg::TERM_DISABLE_BIT] ||
      (st.a_min[6:0] == cal_min);
    hit_hour = st.a_hour[rtcalm_pkg::TERM_DISABLE_BIT] ||
      (st.a_hour[5:0] == cal_hour);
    // Shared register: week mask or day of month
    if (st.a_wd[rtcalm_pkg::TERM_DISABLE_BIT]) begin
      hit_wd = 1'b1;
    end else if (st.ext[rtcalm_pkg::WEEK_DAY_SELECT_BIT]) begin
      // Day-of-month compare
      hit_wd = (st.a_wd[5:0] == cal_date);
    end else begin
      // Any armed weekday
      hit_wd = |(st.a_wd[6:0] & cal_week);
    end
    // Every term off: the match is forced each second
    all_off = st.a_sec[7] && st.a_min[7] && st.a_hour[7] && st.a_wd[7];
    match = hit_sec && hit_min && hit_hour && hit_wd;
  end
  // Address decode over the mapped register indices.
  // Misaligned or out-of-window addresses are never mapped; the
  // answer then carries an error and a write is dropped.
  always_comb begin
    case (idx)
      rtcalm_pkg::ALARM_MINUTE_MATCH_IDX,
      rtcalm_pkg::ALARM_HOUR_MATCH_IDX,
      rtcalm_pkg::ALARM_WEEKDAY_OR_DATE_MATCH_IDX,
      rtcalm_pkg::EXTENSION_CONFIG_IDX,
      rtcalm_pkg::EVENT_FLAGS_IDX,
      rtcalm_pkg::INTERRUPT_CONTROL_IDX,
      rtcalm_pkg::ALARM_SECOND_MATCH_IDX,
      rtcalm_pkg::WAKEUP_PRESET_IDX,
      rtcalm_pkg::CALENDAR_NOW_IDX: mapped = (paddr[11:10] == 2'b00) &&
        (paddr[1:0] == 2'b00);
      // Anything else is refused
      default: mapped = 1'b0;
    endcase
  end
  // Next state: one copy of the whole state, updated in order.
  // Later assignments win, which is how an event beats a clear
  // arriving in the same cycle.
  // Bus ready and error are single-cycle pulses by default.
  always_comb begin
    logic alarm_ev;
    logic timer_ev;
    logic rearm;
    alarm_ev = 1'b0;
    timer_ev = 1'b0;
    rearm = 1'b0;
    next_st = st;
    next_st.rdy = 1'b0;
    next_st.err = 1'b0;
    // Alarm event: sampled only on the second tick, rising match.
    // The previous match is kept across ticks so that a match which
    // simply persists does not fire again on the next second.
    if (sec_tick) begin
      next_st.match_d = match;
      // Stop halts the calendar, and with it every alarm event
      if (!st.ctl[rtcalm_pkg::STOP_BIT]) begin
        if (all_off) begin
          // Nothing to compare: fire every second
          alarm_ev = 1'b1;
        end else begin
          // Only the tick that turns the match true fires
          alarm_ev = match && !st.match_d;
        end
      end
    end
    // Wake-up countdown. Besides expiry, only an enable rising edge loads the preset;
    // a preset of zero leaves the counter idle.
    // On expiry the preset is reloaded and counting goes on, so the
    // interval repeats until the enable is cleared.
    next_st.te_d = te;
    if (te && !st.te_d) begin
      // Enable just went high: fresh countdown
      next_st.count = st.preset;
    end else if (te && timer_tick && st.preset != 24'h000000) begin
      if (st.count <= 24'h000001) begin
        // Last step: flag and reload
        timer_ev = 1'b1;
        next_st.count = st.preset;
      end else begin
        // Plain step down
        next_st.count = st.count - 24'h000001;
      end
    end
    // Register writes, taken on the setup edge.
    // Alarm terms and mode changes re-arm the edge detector below.
    if (wr && mapped) begin
      case (idx)
        rtcalm_pkg::ALARM_SECOND_MATCH_IDX: begin
          next_st.a_sec = pwdata[7:0];
          rearm = 1'b1;
        end
        rtcalm_pkg::ALARM_MINUTE_MATCH_IDX: begin
          next_st.a_min = pwdata[7:0];
          rearm = 1'b1;
        end
        rtcalm_pkg::ALARM_HOUR_MATCH_IDX: begin
          next_st.a_hour = pwdata[7:0];
          rearm = 1'b1;
        end
        rtcalm_pkg::ALARM_WEEKDAY_OR_DATE_MATCH_IDX: begin
          next_st.a_wd = pwdata[7:0];
          rearm = 1'b1;
        end
        rtcalm_pkg::EXTENSION_CONFIG_IDX: begin
          next_st.ext = pwdata[7:0];
          rearm = 1'b1;
        end
        // Control: alarm enable and stop
        rtcalm_pkg::INTERRUPT_CONTROL_IDX: next_st.ctl = pwdata[7:0];
        rtcalm_pkg::WAKEUP_PRESET_IDX: next_st.preset = pwdata[23:0];
        rtcalm_pkg::EVENT_FLAGS_IDX: begin
          // Writing 0 clears, writing 1 ignored
          if (!pwdata[rtcalm_pkg::ALARM_FLAG_BIT]) begin
            next_st.af = 1'b0;
          end
          if (!pwdata[rtcalm_pkg::TIMER_FLAG_BIT]) begin
            next_st.tf = 1'b0;
          end
        end
        // Counter readback and unused indices: nothing to store
        default: ;
      endcase
    end
    // Re-read the present time against the new terms, so that an
    // alarm written equal to it waits for the next match
    if (rearm) begin
      next_st.match_d = terms_hit(next_st.a_sec, next_st.a_min,
        next_st.a_hour, next_st.a_wd,
        next_st.ext[rtcalm_pkg::WEEK_DAY_SELECT_BIT]);
    end
    // Events win over a clear in the same cycle: a clear that
    // lands on the event's edge would otherwise lose an alarm
    // the host has not seen yet
    if (alarm_ev) begin
      next_st.af = 1'b1;
    end
    if (timer_ev) begin
      next_st.tf = 1'b1;
    end
    // Pin: held low while flag set and enable set.
    // Clearing the enable floats the pin but keeps the flag;
    // setting it again pulls the pin while the flag stands.
    next_st.irq_low = next_st.af &&
      next_st.ctl[rtcalm_pkg::ALARM_IRQ_ENABLE_BIT];
    // Read data and answer, produced in the setup cycle
    // and presented with ready in the access phase;
    // unmapped indices read as zero with an error
    if (psel && !penable) begin
      next_st.rdy = 1'b1;
      next_st.err = !mapped;
      next_st.rdata = 32'h00000000;
      // Byte registers fill bits 7:0, the rest read zero
      if (rd && mapped) begin
        case (idx)
          rtcalm_pkg::ALARM_SECOND_MATCH_IDX: next_st.rdata[7:0] = st.a_sec;
          rtcalm_pkg::ALARM_MINUTE_MATCH_IDX: next_st.rdata[7:0] = st.a_min;
          rtcalm_pkg::ALARM_HOUR_MATCH_IDX: next_st.rdata[7:0] = st.a_hour;
          rtcalm_pkg::ALARM_WEEKDAY_OR_DATE_MATCH_IDX:
            next_st.rdata[7:0] = st.a_wd;
          rtcalm_pkg::EXTENSION_CONFIG_IDX: next_st.rdata[7:0] = st.ext;
          rtcalm_pkg::INTERRUPT_CONTROL_IDX: next_st.rdata[7:0] = st.ctl;
          rtcalm_pkg::WAKEUP_PRESET_IDX: next_st.rdata[23:0] = st.preset;
          // Live counter value for software polling
          rtcalm_pkg::CALENDAR_NOW_IDX: next_st.rdata[23:0] = st.count;
          rtcalm_pkg::EVENT_FLAGS_IDX: begin
            next_st.rdata[rtcalm_pkg::ALARM_FLAG_BIT] = st.af;
            next_st.rdata[rtcalm_pkg::TIMER_FLAG_BIT] = st.tf;
          end
          default: ;
        endcase
      end
    end
  end
  // State register; reset clears every field, so the pin floats,
  // the flags are clear and the bus answer is idle
  // (only constants in the reset branch)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  // Outputs straight from flops; open-drain drives 0 only,
  // so the pin is moved by its enable alone
  // Bus answer
  assign prdata = st.rdata;
  assign pready = st.rdy;
  assign pslverr = st.err;
  // Open-drain pin
  assign irq_n_o = 1'b0;
  assign irq_n_oe = !st.irq_low;
  // Wake-up status
  assign timer_flag = st.tf;
  // Checks below watch state and outputs that the block drives
  // Flag stays set unless the host writes the flag register
  // (a tick in that cycle may set it again, never drop it)
  a_flag_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.af && !(wr && idx == rtcalm_pkg::EVENT_FLAGS_IDX) |=> st.af)
    else $error("alarm flag dropped");
  // Pin is low only while both flag and enable are set
  // (the enable alone never pulls the pin)
  a_pin_needs_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    !irq_n_oe |-> st.af && st.ctl[rtcalm_pkg::ALARM_IRQ_ENABLE_BIT])
    else $error("pin low without flag and enable");
  // Stop bit keeps a clear flag clear across a tick,
  // even when every term would match
  a_stop_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_tick && st.ctl[rtcalm_pkg::STOP_BIT] && !st.af |=> !st.af)
    else $error("alarm while stopped");
  // Enable rising edge loads the preset
  a_reload_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    te && !st.te_d |=> st.count == $past(st.preset))
    else $error("no preset load");
  // While enabled, only a source tick moves the counter
  a_start_only_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    te && st.te_d && !timer_tick |=> st.count == $past(st.count))
    else $error("counter moved without a tick");
  // A zero preset keeps the counter still
  a_timer_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.preset == 24'h000000 && !(te && !st.te_d) |=>
      st.count == $past(st.count))
    else $error("idle counter moved");
  // Expiry raises the flag and reloads the preset
  // for the next interval
  a_timer_reload: assert property (
    @(posedge pclk) disable iff (!presetn)
    te && st.te_d && timer_tick && st.preset != 24'h000000 &&
      st.count <= 24'h000001 |=> st.tf && st.count == $past(st.preset))
    else $error("no reload on expiry");
  // Every term off: the next tick sets the flag
  a_all_off_fires: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_tick && !st.ctl[rtcalm_pkg::STOP_BIT] && all_off |=> st.af)
    else $error("no alarm with all terms off");
  // Event with enable set pulls the pin on the next cycle;
  // a register write in that cycle is left out
  a_event_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_tick && !st.ctl[rtcalm_pkg::STOP_BIT] && all_off && !wr &&
      st.ctl[rtcalm_pkg::ALARM_IRQ_ENABLE_BIT] |=> !irq_n_oe)
    else $error("event did not pull the pin");
  // Clearing the flag floats the pin when no tick competes
  a_clear_releases: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && mapped && idx == rtcalm_pkg::EVENT_FLAGS_IDX && !sec_tick &&
      !pwdata[rtcalm_pkg::ALARM_FLAG_BIT] |=> irq_n_oe)
    else $error("pin held after flag clear");
  // Stop also keeps a floating pin floating
  a_stop_no_pin: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_tick && st.ctl[rtcalm_pkg::STOP_BIT] && irq_n_oe && !wr |=> irq_n_oe)
    else $error("pin pulled while stopped");
  // The flag only rises after a second tick
  a_flag_needs_tick: assert property (
    @(posedge pclk) disable iff (!presetn)
    !st.af ##1 st.af |-> $past(sec_tick))
    else $error("flag rose without a tick");
  // Bus answer lasts one cycle, an error only with it
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");
endmodule
